// file: include/sfm_pkg.sv
/*
 * sfm_pkg: register map, field positions, reset values, read opcodes
 * and sequencer states of the serial flash read master.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package sfm_pkg;

    // register byte offsets
    localparam logic [7:0] SFM_OFS_CFG = 8'h00;
    localparam logic [7:0] SFM_OFS_PIN = 8'h14;
    localparam logic [7:0] SFM_OFS_STAT = 8'h18;

    // flash_master_config fields
    localparam int SFM_CFG_FAST_BIT = 10;
    localparam int SFM_CFG_IDLE_LSB = 5;
    localparam int SFM_CFG_DIV_LSB = 0;
    localparam int SFM_FIELD5_W = 5;

    // pin_control_mode fields
    localparam int SFM_PIN_EN_BIT = 13;
    localparam int SFM_PIN_CK_BIT = 12;
    localparam int SFM_PIN_CKOE_BIT = 11;
    localparam int SFM_PIN_DO_BIT = 10;
    localparam int SFM_PIN_DOOE_BIT = 9;
    localparam int SFM_PIN_CS_BIT = 5;
    localparam int SFM_PIN_CSOE_BIT = 1;
    localparam int SFM_PIN_SDI_BIT = 0;

    // status fields
    localparam int SFM_STAT_BUSY_BIT = 0;
    localparam int SFM_STAT_PEND_BIT = 1;
    localparam int SFM_STAT_FULL_BIT = 2;

    // values after reset
    localparam logic SFM_FAST_RST = 1'b0;
    localparam logic [4:0] SFM_IDLE_RST = 5'h1f;
    localparam logic [4:0] SFM_DIV_RST = 5'h1f;
    localparam logic SFM_PIN_RST = 1'b0;

    // read instructions and command lengths in serial clocks
    localparam logic [7:0] SFM_OP_READ = 8'h03;
    localparam logic [7:0] SFM_OP_FAST = 8'h0b;
    localparam logic [5:0] SFM_CMD_BITS = 6'h20;
    localparam logic [5:0] SFM_FAST_BITS = 6'h28;

    typedef enum logic [2:0] {
        SFM_IDLE = 3'b001,
        SFM_SHIFT = 3'b010,
        SFM_DESEL = 3'b100
    } sfm_state_t;

endpackage : sfm_pkg

// file: sim/sfm_flash_model.sv
/* sfm_flash_model: behavioural mode 0 serial flash answering reads.
   Assumes pin levels already resolved from the drive enables. */
`timescale 1ns/1ns
module sfm_flash_model (
    // serial pins
    input wire logic sck,
    input wire logic sel_n,
    input wire logic si,
    output logic so,
    // last command seen
    output logic [7:0] op_seen,
    output logic [23:0] adr_seen
);
    int n = 0;
    int h;
    logic [31:0] cmd = 32'h0;
    logic [7:0] b;
    initial begin
        so = 1'b0;
        op_seen = 8'h0;
        adr_seen = 24'h0;
    end
    always @(negedge sel_n) n = 0;
    always @(posedge sck) begin
        if (!sel_n) begin
            cmd = {cmd[30:0], si};
            n++;
            if (n == 32) begin
                op_seen = cmd[31:24];
                adr_seen = cmd[23:0];
            end
        end
    end
    // byte value is its address low byte xor 5a
    always @(negedge sck) begin
        if (!sel_n) begin
            h = (op_seen == 8'h0b) ? 40 : 32;
            b = 8'(adr_seen[7:0] + (n - h) / 8) ^ 8'h5a;
            so <= (n >= h) ? b[7 - (n - h) % 8] : ~so;
        end
    end
    // released line shows the inverse of its last level
    always @(posedge sel_n) so <= ~so;
endmodule : sfm_flash_model

// file: sim/sfm_master_properties.sv
/* sfm_master_props: port checks of the flash read master.
   Assumes binding into sfm_master; registers mirrored from apb. */
`timescale 1ns/1ns
module sfm_master_props
    import sfm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb and read request
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic rd_valid,
    input wire logic rd_ready,
    // flash pins
    input wire logic flash_clk_o,
    input wire logic flash_clk_oe,
    input wire logic flash_data_out_o,
    input wire logic flash_data_out_oe,
    input wire logic flash_select_n_o,
    input wire logic flash_select_n_oe
);
    logic [31:0] cfg_r, pin_r;
    logic [9:0] hc_r;
    logic [10:0] sh_r;
    logic [5:0] bc_r;
    logic [7:0] sr_r;
    logic ck_r;
    logic bb;
    logic wr;
    assign bb = pin_r[SFM_PIN_EN_BIT];
    assign wr = psel && penable && pwrite;
    // register mirror, high time, deselect time, command bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= 32'h3ff;
            pin_r <= 32'h0;
            hc_r <= 10'h0;
            // no earlier transfer to keep apart from after reset
            sh_r <= 11'h7ff;
            bc_r <= 6'h0;
            sr_r <= 8'h0;
            ck_r <= 1'b0;
        end else begin
            if (wr && paddr == SFM_OFS_CFG)
                cfg_r <= pwdata;
            if (wr && paddr == SFM_OFS_PIN)
                pin_r <= pwdata;
            ck_r <= flash_clk_o;
            hc_r <= flash_clk_o ? hc_r + 10'h1 : 10'h0;
            sh_r <= flash_select_n_o ? sh_r + {10'h0, ~&sh_r} : 11'h0;
            if (flash_select_n_o)
                bc_r <= 6'h0;
            else if (flash_clk_o && !ck_r && bc_r != 6'h3f) begin
                bc_r <= bc_r + 6'h1;
                sr_r <= {sr_r[6:0], flash_data_out_o};
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; rd_valid && rd_ready; endsequence
    sequence s_sel; !flash_select_n_o; endsequence
    a_clk_pin: assert property (bb && $stable(pin_r) |->
        flash_clk_oe == pin_r[11] && (!pin_r[11] || flash_clk_o == pin_r[12]))
        else $error("bitbang clock pin wrong");
    a_data_pin: assert property (bb && $stable(pin_r) |->
        flash_data_out_oe == pin_r[9] &&
        (!pin_r[9] || flash_data_out_o == pin_r[10])) else $error("data pin");
    a_sel_pin: assert property (bb && $stable(pin_r) |->
        flash_select_n_oe == pin_r[1] &&
        (!pin_r[1] || flash_select_n_o == pin_r[5])) else $error("select pin");
    a_hw_drive: assert property (!bb && $stable(pin_r) |->
        flash_clk_oe && flash_data_out_oe && flash_select_n_oe)
        else $error("hardware mode pins not driven");
    a_clk_idle: assert property (!bb && $stable(pin_r) &&
        flash_select_n_o |-> !flash_clk_o) else $error("clock not idle low");
    a_start_sel: assert property (s_take |=> s_sel)
        else $error("select not low after accept");
    a_desel_gap: assert property (!bb && $stable(pin_r) &&
        $fell(flash_select_n_o) |-> sh_r >= cfg_r[9:5] * cfg_r[4:0])
        else $error("deselect time too short");
    a_clk_high: assert property (!bb && $stable(pin_r) &&
        $fell(flash_clk_o) |-> hc_r == cfg_r[4:0] - cfg_r[4:0] / 5'h2)
        else $error("serial clock high time wrong");
    a_read_op: assert property (!bb && bc_r == 6'h8 &&
        $past(bc_r) == 6'h7 |-> sr_r == (cfg_r[10] ? SFM_OP_FAST : SFM_OP_READ))
        else $error("read opcode wrong");
endmodule : sfm_master_props

// file: sim/sfm_master_test.sv
/* sfm_master_test: registers, hardware reads, fifo and pin control.
   Assumes the flash model on the pins and the bound port checker. */
`timescale 1ns/1ns
module sfm_master_test
    import sfm_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic rd_valid = 1'b0;
    logic [23:0] rd_addr = 24'h0;
    logic [15:0] rd_len = 16'h0;
    logic dout_ready = 1'b0;
    logic pready, pslverr, rd_ready, dout_valid, e;
    logic ck_o, ck_oe, do_o, do_oe, cs_o, cs_oe, di;
    logic [31:0] prdata, q;
    logic [7:0] dout_data, op_seen;
    logic [23:0] adr_seen;
    int err_total = 0;
    int tests_run = 0;
    // read cases: config, length, address, stall cycles
    logic [31:0] cfgs [3] = '{32'h7e4, 32'h45, 32'h424};
    int lens [3] = '{1, 8, 20};
    logic [23:0] adrs [3] = '{24'h100, 24'h12345, 24'hfffffe};
    int stalls [3] = '{0, 0, 900};
    // undriven clock and data pulled low, select pulled high
    wire logic ck_w = ck_oe ? ck_o : 1'b0;
    wire logic do_w = do_oe ? do_o : 1'b0;
    wire logic cs_w = cs_oe ? cs_o : 1'b1;
    always #25 sys_clk = ~sys_clk;
    sfm_master u_sfm_master (
        .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .rd_valid, .rd_ready, .rd_addr, .rd_len,
        .dout_valid, .dout_ready, .dout_data, .flash_clk_o(ck_o),
        .flash_clk_oe(ck_oe), .flash_data_out_o(do_o),
        .flash_data_out_oe(do_oe), .flash_select_n_o(cs_o),
        .flash_select_n_oe(cs_oe), .flash_data_in(di)
    );
    sfm_flash_model u_sfm_flash_model (
        .sck(ck_w), .sel_n(cs_w), .si(do_w), .so(di), .op_seen, .adr_seen
    );
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input int k);
        int i;
        @(posedge sys_clk);
        rd_valid <= 1'b1;
        rd_addr <= adrs[k];
        rd_len <= 16'(lens[k] - 1);
        do @(posedge sys_clk); while (rd_ready !== 1'b1);
        rd_valid <= 1'b0;
        if (stalls[k] > 0) begin
            repeat (stalls[k]) @(posedge sys_clk);
            apb(1'b0, SFM_OFS_STAT, 32'h0);
            cmp(q[SFM_STAT_FULL_BIT:SFM_STAT_BUSY_BIT], 3'h7);
        end
        dout_ready <= 1'b1;
        i = 0;
        while (i < lens[k]) begin
            @(posedge sys_clk);
            if (dout_valid === 1'b1) begin
                cmp(dout_data, 8'(adrs[k][7:0] + i) ^ 8'h5a);
                i++;
            end
        end
        dout_ready <= 1'b0;
        cmp(op_seen, cfgs[k][10] ? SFM_OP_FAST : SFM_OP_READ);
        cmp(adr_seen, adrs[k]);
    endtask : rd_chk
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, SFM_OFS_CFG, 32'h0);
        cmp(q, 32'h3ff);
        apb(1'b0, SFM_OFS_PIN, 32'h0);
        cmp(q, {31'h0, di});
        apb(1'b0, 8'h08, 32'h0);
        cmp(e, 1'b1);
        apb(1'b1, SFM_OFS_PIN, 32'h1e22);
        repeat (2) @(posedge sys_clk);
        cmp({ck_oe, do_oe, cs_oe, cs_o, ck_o}, 5'h1e);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, SFM_OFS_CFG, cfgs[k]);
            apb(1'b0, SFM_OFS_CFG, 32'h0);
            cmp(q, cfgs[k]);
            rd_chk(k);
        end
        apb(1'b1, SFM_OFS_PIN, 32'h3a20);
        repeat (2) @(posedge sys_clk);
        cmp({ck_o, ck_oe, do_o, do_oe, cs_oe, rd_ready}, 6'h34);
        apb(1'b1, SFM_OFS_PIN, 32'h2602);
        repeat (2) @(posedge sys_clk);
        cmp({ck_oe, do_o, do_oe, cs_o, cs_oe}, 5'h0d);
        apb(1'b0, SFM_OFS_PIN, 32'h0);
        cmp(q, {31'h1301, di});
        report_and_stop;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        report_and_stop;
    end
endmodule : sfm_master_test
bind sfm_master sfm_master_props u_sfm_master_props (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .rd_valid,
    .rd_ready, .flash_clk_o, .flash_clk_oe, .flash_data_out_o,
    .flash_data_out_oe, .flash_select_n_o, .flash_select_n_oe
);

// file: src/sfm_fifo.sv
/*
 * sfm_fifo: received-byte FIFO with registered read data.
 * Assumes one clock; source and sink both use valid/ready.
 */
`timescale 1ns/1ns
module sfm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("sfm_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ovalid;
        logic [W-1:0] odata;
    } sfm_fifo_st_t;

    sfm_fifo_st_t q_r;
    sfm_fifo_st_t q_nxt;
    logic push;
    logic pop;

    assign in_ready = (q_r.cnt != (AW + 1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = q_r.ovalid;
    assign out_data = q_r.odata;

    always_comb begin
        q_nxt = q_r;
        push = in_valid && in_ready;
        // output register refills whenever it is empty or being taken
        pop = (q_r.cnt != '0) && (!q_r.ovalid || out_ready);
        if (q_r.ovalid && out_ready) begin
            q_nxt.ovalid = 1'b0;
        end
        if (pop) begin
            q_nxt.odata = q_r.mem[q_r.rp];
            q_nxt.ovalid = 1'b1;
            q_nxt.rp = q_r.rp + 1'b1;
        end
        if (push) begin
            q_nxt.mem[q_r.wp] = in_data;
            q_nxt.wp = q_r.wp + 1'b1;
        end
        q_nxt.cnt = q_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule : sfm_fifo

// file: src/sfm_master.sv
/*
 * sfm_master: serial flash read master with APB registers, a hardware
 * read sequencer, software pin control and a byte FIFO on read data.
 * Assumes the flash is a mode 0 serial flash; pin inputs are async.
 *
// How it works
// - read_type_select at 0 makes every hardware read use opcode 03.
// - read_type_select at 1 makes every hardware read use opcode 0b.
// - flash_select_n stays high select_idle_cycles serial clocks.
// - the serial clock is sys_clk divided by the divider field.
// - bitbang_enable hands the pins to software and stops the sequencer.
// - in bitbang mode the clock pin follows its value and drive bits.
// - in bitbang mode the data-out pin follows its value and drive bits.
// - in bitbang mode the select pin follows its value and drive bits.
// - the bitbang value and drive bits act only in bitbang mode.
// - datain_level always reads the synchronised data-in pin.
 */
`timescale 1ns/1ns
module sfm_master
    import sfm_pkg::*;
#(
    parameter int LEN_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // read request
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [23:0] rd_addr,
    input wire logic [LEN_W-1:0] rd_len,
    // read data stream
    output logic dout_valid,
    input wire logic dout_ready,
    output logic [7:0] dout_data,
    // flash pins
    output logic flash_clk_o,
    output logic flash_clk_oe,
    output logic flash_data_out_o,
    output logic flash_data_out_oe,
    output logic flash_select_n_o,
    output logic flash_select_n_oe,
    input wire logic flash_data_in
);

    generate
        if (LEN_W < 1 || LEN_W > 24) begin : g_chk
            $error("sfm_master: LEN_W must lie in 1..24");
        end
    endgenerate

    typedef struct packed {
        sfm_state_t st;
        logic read_type_select;
        logic [4:0] select_idle_cycles;
        logic [4:0] clk_div;
        logic bitbang_enable;
        logic bitbang_clock_value;
        logic bitbang_clock_drive;
        logic bitbang_dataout_value;
        logic bitbang_dataout_drive;
        logic bitbang_select_value;
        logic bitbang_select_drive;
        logic sdi_s1;
        logic sdi_s2;
        logic sclk;
        logic sdo;
        logic sel_n;
        logic [4:0] dcnt;
        logic [4:0] dsc;
        logic [5:0] bitn;
        logic [5:0] ncmd;
        logic [39:0] sh;
        logic [7:0] rx;
        logic [2:0] rxn;
        logic [1:0] take_d;
        logic [1:0] last_d;
        logic [LEN_W-1:0] left;
        logic pend;
        logic [7:0] pdata;
        logic [31:0] prdata;
        logic o_clk;
        logic o_clk_oe;
        logic o_do;
        logic o_do_oe;
        logic o_sel_n;
        logic o_sel_oe;
    } sfm_st_t;

    sfm_st_t q_r;
    sfm_st_t q_nxt;
    logic fifo_ready;
    logic [4:0] lo_half;
    logic [4:0] hi_half;
    logic [31:0] rd_mux;
    logic hit;
    logic [7:0] op;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = q_r.prdata;
    assign rd_ready = (q_r.st == SFM_IDLE) && !q_r.bitbang_enable;
    assign flash_clk_o = q_r.o_clk;
    assign flash_clk_oe = q_r.o_clk_oe;
    assign flash_data_out_o = q_r.o_do;
    assign flash_data_out_oe = q_r.o_do_oe;
    assign flash_select_n_o = q_r.o_sel_n;
    assign flash_select_n_oe = q_r.o_sel_oe;

    // address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            SFM_OFS_CFG: begin
                rd_mux[SFM_CFG_FAST_BIT] = q_r.read_type_select;
                rd_mux[SFM_CFG_IDLE_LSB +: SFM_FIELD5_W] =
                    q_r.select_idle_cycles;
                rd_mux[SFM_CFG_DIV_LSB +: SFM_FIELD5_W] = q_r.clk_div;
            end
            SFM_OFS_PIN: begin
                rd_mux[SFM_PIN_EN_BIT] = q_r.bitbang_enable;
                rd_mux[SFM_PIN_CK_BIT] = q_r.bitbang_clock_value;
                rd_mux[SFM_PIN_CKOE_BIT] = q_r.bitbang_clock_drive;
                rd_mux[SFM_PIN_DO_BIT] = q_r.bitbang_dataout_value;
                rd_mux[SFM_PIN_DOOE_BIT] = q_r.bitbang_dataout_drive;
                rd_mux[SFM_PIN_CS_BIT] = q_r.bitbang_select_value;
                rd_mux[SFM_PIN_CSOE_BIT] = q_r.bitbang_select_drive;
                rd_mux[SFM_PIN_SDI_BIT] = q_r.sdi_s2;
            end
            SFM_OFS_STAT: begin
                rd_mux[SFM_STAT_BUSY_BIT] = (q_r.st != SFM_IDLE);
                rd_mux[SFM_STAT_PEND_BIT] = q_r.pend;
                rd_mux[SFM_STAT_FULL_BIT] = !fifo_ready;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        q_nxt = q_r;
        // mode 0 half periods; low half takes the shorter share
        lo_half = {1'b0, q_r.clk_div[4:1]};
        hi_half = q_r.clk_div - lo_half;
        op = q_r.read_type_select ? SFM_OP_FAST : SFM_OP_READ;

        q_nxt.sdi_s1 = flash_data_in;
        q_nxt.sdi_s2 = q_r.sdi_s1;

        if (q_r.pend && fifo_ready) begin
            q_nxt.pend = 1'b0;
        end

        // synchroniser lag: shift in the bit two clocks after its rise
        q_nxt.take_d = {q_r.take_d[0], 1'b0};
        q_nxt.last_d = {q_r.last_d[0], 1'b0};
        if (q_r.take_d[1]) begin
            q_nxt.rx = {q_r.rx[6:0], q_r.sdi_s2};
            if (q_r.last_d[1]) begin
                q_nxt.pend = 1'b1;
                q_nxt.pdata = {q_r.rx[6:0], q_r.sdi_s2};
            end
        end

        // register access
        if (psel && !penable) begin
            q_nxt.prdata = rd_mux;
        end
        if (psel && penable && pwrite) begin
            if (paddr == SFM_OFS_CFG) begin
                q_nxt.read_type_select = pwdata[SFM_CFG_FAST_BIT];
                q_nxt.select_idle_cycles =
                    pwdata[SFM_CFG_IDLE_LSB +: SFM_FIELD5_W];
                q_nxt.clk_div = pwdata[SFM_CFG_DIV_LSB +: SFM_FIELD5_W];
            end
            if (paddr == SFM_OFS_PIN) begin
                q_nxt.bitbang_enable = pwdata[SFM_PIN_EN_BIT];
                q_nxt.bitbang_clock_value = pwdata[SFM_PIN_CK_BIT];
                q_nxt.bitbang_clock_drive = pwdata[SFM_PIN_CKOE_BIT];
                q_nxt.bitbang_dataout_value = pwdata[SFM_PIN_DO_BIT];
                q_nxt.bitbang_dataout_drive = pwdata[SFM_PIN_DOOE_BIT];
                q_nxt.bitbang_select_value = pwdata[SFM_PIN_CS_BIT];
                q_nxt.bitbang_select_drive = pwdata[SFM_PIN_CSOE_BIT];
            end
        end

        // hardware read sequencer
        case (q_r.st)
            SFM_IDLE: begin
                q_nxt.sclk = 1'b0;
                q_nxt.sel_n = 1'b1;
                q_nxt.dcnt = '0;
                if (rd_valid && rd_ready) begin
                    q_nxt.st = SFM_SHIFT;
                    q_nxt.sel_n = 1'b0;
                    q_nxt.sh = {op, rd_addr, 8'h00};
                    q_nxt.sdo = op[7];
                    q_nxt.bitn = '0;
                    q_nxt.ncmd = q_r.read_type_select ?
                        SFM_FAST_BITS : SFM_CMD_BITS;
                    q_nxt.left = rd_len;
                    q_nxt.rxn = '0;
                end
            end
            SFM_SHIFT: begin
                q_nxt.dcnt = q_r.dcnt + 5'h01;
                if (!q_r.sclk) begin
                    // hold the rising edge while a byte waits for the fifo
                    if (q_r.dcnt + 5'h01 >= lo_half) begin
                        q_nxt.dcnt = q_r.dcnt;
                        if (!q_r.pend) begin
                            q_nxt.sclk = 1'b1;
                            q_nxt.dcnt = '0;
                            if (q_r.bitn >= q_r.ncmd) begin
                                // pin level at this rise, shifted in later
                                q_nxt.take_d[0] = 1'b1;
                                q_nxt.last_d[0] = (q_r.rxn == 3'h7);
                                q_nxt.rxn = q_r.rxn + 3'h1;
                            end
                        end
                    end
                end else if (q_r.dcnt + 5'h01 >= hi_half) begin
                    q_nxt.sclk = 1'b0;
                    q_nxt.dcnt = '0;
                    if (q_r.bitn < q_r.ncmd) begin
                        // next command bit goes out on the falling edge
                        q_nxt.bitn = q_r.bitn + 6'h01;
                        q_nxt.sh = {q_r.sh[38:0], 1'b0};
                        q_nxt.sdo = q_r.sh[38];
                    end else if (q_r.rxn == 3'h0) begin
                        if (q_r.left == '0) begin
                            q_nxt.st = SFM_DESEL;
                            q_nxt.sel_n = 1'b1;
                            q_nxt.dsc = '0;
                        end else begin
                            q_nxt.left = q_r.left - 1'b1;
                        end
                    end
                end
            end
            SFM_DESEL: begin
                // count whole serial clock periods with select high
                q_nxt.dcnt = q_r.dcnt + 5'h01;
                if (q_r.dcnt + 5'h01 >= q_r.clk_div) begin
                    q_nxt.dcnt = '0;
                    q_nxt.dsc = q_r.dsc + 5'h01;
                    if (q_r.dsc + 5'h01 >= q_r.select_idle_cycles) begin
                        q_nxt.st = SFM_IDLE;
                    end
                end
            end
            default: begin
                q_nxt.st = SFM_IDLE;
            end
        endcase

        // pin control abandons any hardware transfer
        if (q_r.bitbang_enable) begin
            q_nxt.st = SFM_IDLE;
            q_nxt.sclk = 1'b0;
            q_nxt.sel_n = 1'b1;
        end

        // pin multiplexer
        if (q_nxt.bitbang_enable) begin
            q_nxt.o_clk = q_nxt.bitbang_clock_value;
            q_nxt.o_clk_oe = q_nxt.bitbang_clock_drive;
            q_nxt.o_do = q_nxt.bitbang_dataout_value;
            q_nxt.o_do_oe = q_nxt.bitbang_dataout_drive;
            q_nxt.o_sel_n = q_nxt.bitbang_select_value;
            q_nxt.o_sel_oe = q_nxt.bitbang_select_drive;
        end else begin
            q_nxt.o_clk = q_nxt.sclk;
            q_nxt.o_clk_oe = 1'b1;
            q_nxt.o_do = q_nxt.sdo;
            q_nxt.o_do_oe = 1'b1;
            q_nxt.o_sel_n = q_nxt.sel_n;
            q_nxt.o_sel_oe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '0;
            q_r.st <= SFM_IDLE;
            q_r.read_type_select <= SFM_FAST_RST;
            q_r.select_idle_cycles <= SFM_IDLE_RST;
            q_r.clk_div <= SFM_DIV_RST;
            q_r.bitbang_enable <= SFM_PIN_RST;
            q_r.sel_n <= 1'b1;
            q_r.o_sel_n <= 1'b1;
            q_r.o_clk_oe <= 1'b1;
            q_r.o_do_oe <= 1'b1;
            q_r.o_sel_oe <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    sfm_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(q_r.pend),
        .in_ready(fifo_ready),
        .in_data(q_r.pdata),
        .out_valid(dout_valid),
        .out_ready(dout_ready),
        .out_data(dout_data)
    );

endmodule : sfm_master
